/* File: asps_map.svh */
// register map, timing counts and field positions of the axis select parallel port
`ifndef ASPS_MAP_SVH
`define ASPS_MAP_SVH

`define ASPS_CLK_HZ 10000000
`define ASPS_FILTER_MS 10
`define ASPS_FAST_MS 4
`define ASPS_CLEAR_MS 10
`define ASPS_CHECK_MS 1
`define ASPS_FILTER_CYC (`ASPS_FILTER_MS * (`ASPS_CLK_HZ / 1000))
`define ASPS_FAST_CYC (`ASPS_FAST_MS * (`ASPS_CLK_HZ / 1000))
`define ASPS_CLEAR_CYC (`ASPS_CLEAR_MS * (`ASPS_CLK_HZ / 1000))
`define ASPS_CHECK_CYC (`ASPS_CHECK_MS * (`ASPS_CLK_HZ / 1000))

`define ASPS_REG_CTRL 8'h00
`define ASPS_REG_STATUS 8'h04
`define ASPS_REG_IRQ_STAT 8'h08
`define ASPS_REG_IRQ_CLR 8'h0C
`define ASPS_REG_IRQ_EN 8'h10
`define ASPS_REG_ERR_RING 8'h14
`define ASPS_REG_PRESET_HI 3'h1

`define ASPS_CTRL_FAST 0
`define ASPS_CTRL_CNT_LSB 4
`define ASPS_AXES_RST 3'h7
`define ASPS_TMO_LIMIT 3'h5

`define ASPS_IRQ_STROBE 0
`define ASPS_IRQ_INVALID 1
`define ASPS_IRQ_NOTREADY 2
`define ASPS_IRQ_PRESET 3

`define ASPS_ERR_INVALID 4'h1
`define ASPS_ERR_MISSING 4'h2
`define ASPS_ERR_READBACK 4'h3
`define ASPS_ERR_BADPOS 4'h4
`define ASPS_ERR_TIMEOUT 4'h5

`define ASPS_RESP_OKAY 2'h0
`define ASPS_RESP_SLVERR 2'h2

`endif

/* File: asps_pkg.sv */
// types shared by the axis select parallel port files
package asps_pkg;
   localparam int CNT_W = 17;
   localparam int IN_N = 9;
   typedef logic [CNT_W-1:0] asps_cnt_t;

   typedef struct packed {
      logic preset_two;
      logic preset_one;
      logic release_req;
      logic hold;
      logic clear;
      logic strobe;
      logic [2:0] sel;
   } asps_in_t;

   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } asps_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } asps_axi_rsp_t;

   typedef struct packed {
      logic [IN_N-1:0] sync1;
      logic [IN_N-1:0] sync2;
      logic [IN_N-1:0] level;
      logic [IN_N-1:0][CNT_W-1:0] cnt;
   } asps_filt_t;

   typedef struct packed {
      logic aw_held;
      logic [7:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic fast;
      logic [2:0] axis_count;
      logic [7:0][19:0] preset;
      logic [7:0][19:0] offset;
      asps_in_t in_d;
      logic [2:0] axis;
      logic [23:0] dout;
      logic oe_n;
      logic ready;
      logic fault;
      logic [2:0] tmo_cnt;
      logic clr_wait;
      logic [CNT_W-1:0] clr_cnt;
      logic [CNT_W-1:0] chk_cnt;
      logic [3:0][3:0] ring;
      logic [2:0] ring_cnt;
      logic [1:0] ring_ptr;
      logic [3:0] irq_stat;
      logic [3:0] irq_en;
   } asps_state_t;
endpackage

/* File: asps_filter.sv */
// two-flop synchroniser and stability filter for the control inputs
`timescale 1ns/1ps
`default_nettype none
module asps_filter #(
   parameter int SLOW_CYCLES = 100000,
   parameter int FAST_CYCLES = 40000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic fast,
   input wire logic [asps_pkg::IN_N-1:0] raw,
   output logic [asps_pkg::IN_N-1:0] level
);
   asps_pkg::asps_filt_t s;
   asps_pkg::asps_filt_t n;
   asps_pkg::asps_cnt_t last;

   always_comb
   begin
      n = s;
      last = fast ? asps_pkg::asps_cnt_t'(FAST_CYCLES - 1)
                  : asps_pkg::asps_cnt_t'(SLOW_CYCLES - 1);
      n.sync1 = raw;
      n.sync2 = s.sync1;
      for (int i = 0; i < asps_pkg::IN_N; i++)
      begin
         // any return to the accepted level restarts the stability count
         if (s.sync2[i] == s.level[i])
         begin
            n.cnt[i] = '0;
         end
         else if (s.cnt[i] == last)
         begin
            n.level[i] = s.sync2[i];
            n.cnt[i] = '0;
         end
         else
         begin
            n.cnt[i] = s.cnt[i] + 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
      end
      else
      begin
         s <= n;
      end
   end

   assign level = s.level;
endmodule
`default_nettype wire

/* File: asps_port.sv */
// axis select parallel position port with AXI4-Lite control registers
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "asps_map.svh"
module asps_port #(
   parameter int FILTER_CYCLES = `ASPS_FILTER_CYC,
   parameter int FAST_CYCLES = `ASPS_FAST_CYC,
   parameter int CLEAR_CYCLES = `ASPS_CLEAR_CYC,
   parameter int CHECK_CYCLES = `ASPS_CHECK_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire asps_pkg::asps_axi_req_t axi_req,
   output asps_pkg::asps_axi_rsp_t axi_rsp,
   input wire logic axis_select_bit0,
   input wire logic axis_select_bit1,
   input wire logic axis_select_bit2,
   input wire logic axis_strobe_in,
   input wire logic clear_errors_in,
   input wire logic output_hold_in,
   input wire logic output_release_in,
   input wire logic preset_one_in,
   input wire logic preset_two_in,
   input wire logic [7:0][19:0] axis_position,
   input wire logic [7:0] axis_fault,
   input wire logic encoder_missing,
   input wire logic readback_mismatch,
   input wire logic bad_position,
   input wire logic measure_timeout,
   input wire logic measure_done,
   output logic [23:0] parallel_data_out,
   output logic parallel_data_oe_n,
   output logic ready_relay_out,
   output logic irq
);
   asps_pkg::asps_state_t s;
   asps_pkg::asps_state_t n;
   asps_pkg::asps_in_t raw;
   asps_pkg::asps_in_t fin;
   logic [asps_pkg::IN_N-1:0] fin_bits;
   logic strobe_rise;
   logic preset_rise;
   logic clear_rise;
   logic check_tick;
   logic any_fault;
   logic wr_go;
   logic [3:0] irq_set;
   logic [3:0] irq_clr;
   logic [31:0] rd;
   logic [1:0] rresp;
   logic [31:0] wtmp;
   logic [19:0] pos;

   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] nw,
      input logic [3:0] strb
   );
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic is_preset(input logic [7:0] a);
      return (a[7:5] == `ASPS_REG_PRESET_HI) && (a[4:2] != 3'h0);
   endfunction

   assign raw.sel = {axis_select_bit2, axis_select_bit1, axis_select_bit0};
   assign raw.strobe = axis_strobe_in;
   assign raw.clear = clear_errors_in;
   assign raw.hold = output_hold_in;
   assign raw.release_req = output_release_in;
   assign raw.preset_one = preset_one_in;
   assign raw.preset_two = preset_two_in;

   // every select and control pin goes through the synchroniser and the stability filter
   asps_filter #(
      .SLOW_CYCLES(FILTER_CYCLES),
      .FAST_CYCLES(FAST_CYCLES)
   ) u_filter (
      .aclk(aclk),
      .aresetn(aresetn),
      .fast(s.fast),
      .raw(raw),
      .level(fin_bits)
   );
   assign fin = fin_bits;

   assign strobe_rise = fin.strobe && !s.in_d.strobe;
   assign preset_rise = (fin.preset_one && !s.in_d.preset_one)
                     || (fin.preset_two && !s.in_d.preset_two);
   assign clear_rise = fin.clear && !s.in_d.clear;
   assign check_tick = (s.chk_cnt == '0);
   assign any_fault = encoder_missing || readback_mismatch || bad_position
                   || (s.tmo_cnt >= `ASPS_TMO_LIMIT);
   assign wr_go = s.aw_held && s.w_held && !s.bvalid;

   always_comb
   begin
      n = s;
      irq_set = '0;
      irq_clr = '0;
      rd = '0;
      rresp = `ASPS_RESP_OKAY;
      wtmp = '0;
      pos = '0;
      n.in_d = fin;

      // write channel: address and data may arrive in either order
      if (axi_req.awvalid && !s.aw_held && !s.bvalid)
      begin
         n.aw_held = 1'b1;
         n.awaddr = axi_req.awaddr;
      end
      if (axi_req.wvalid && !s.w_held && !s.bvalid)
      begin
         n.w_held = 1'b1;
         n.wdata = axi_req.wdata;
         n.wstrb = axi_req.wstrb;
      end
      if (s.bvalid && axi_req.bready)
      begin
         n.bvalid = 1'b0;
      end
      if (wr_go)
      begin
         n.aw_held = 1'b0;
         n.w_held = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `ASPS_RESP_OKAY;
         case ({s.awaddr[7:2], 2'b00})
            `ASPS_REG_CTRL:
            begin
               wtmp = merge({25'h0, s.axis_count, 3'h0, s.fast}, s.wdata, s.wstrb);
               n.fast = wtmp[`ASPS_CTRL_FAST];
               n.axis_count = wtmp[`ASPS_CTRL_CNT_LSB +: 3];
            end
            `ASPS_REG_IRQ_CLR:
            begin
               wtmp = merge(32'h0, s.wdata, s.wstrb);
               irq_clr = wtmp[3:0];
            end
            `ASPS_REG_IRQ_EN:
            begin
               wtmp = merge({28'h0, s.irq_en}, s.wdata, s.wstrb);
               n.irq_en = wtmp[3:0];
            end
            `ASPS_REG_STATUS, `ASPS_REG_IRQ_STAT, `ASPS_REG_ERR_RING:
            begin
               n.bresp = `ASPS_RESP_OKAY;
            end
            default:
            begin
               if (is_preset(s.awaddr))
               begin
                  wtmp = merge({12'h0, s.preset[s.awaddr[4:2]]}, s.wdata, s.wstrb);
                  n.preset[s.awaddr[4:2]] = wtmp[19:0];
               end
               else
               begin
                  n.bresp = `ASPS_RESP_SLVERR;
               end
            end
         endcase
      end

      // read channel: one read outstanding, answer registered
      if (s.rvalid && axi_req.rready)
      begin
         n.rvalid = 1'b0;
      end
      if (axi_req.arvalid && !s.rvalid)
      begin
         case ({axi_req.araddr[7:2], 2'b00})
            `ASPS_REG_CTRL:
            begin
               rd = {25'h0, s.axis_count, 3'h0, s.fast};
            end
            `ASPS_REG_STATUS:
            begin
               rd = {21'h0, s.ring_cnt, s.tmo_cnt, s.fault, s.ready, s.axis};
            end
            `ASPS_REG_IRQ_STAT:
            begin
               rd = {28'h0, s.irq_stat};
            end
            `ASPS_REG_IRQ_CLR:
            begin
               rd = '0;
            end
            `ASPS_REG_IRQ_EN:
            begin
               rd = {28'h0, s.irq_en};
            end
            `ASPS_REG_ERR_RING:
            begin
               rd = {16'h0, s.ring};
            end
            default:
            begin
               if (is_preset(axi_req.araddr))
               begin
                  rd = {12'h0, s.preset[axi_req.araddr[4:2]]};
               end
               else
               begin
                  rresp = `ASPS_RESP_SLVERR;
               end
            end
         endcase
         n.rvalid = 1'b1;
         n.rdata = rd;
         n.rresp = rresp;
      end

      // axis selection on the filtered strobe edge
      if (strobe_rise)
      begin
         if (fin.sel == 3'h0)
         begin
            n.axis = 3'h0;
            irq_set[`ASPS_IRQ_STROBE] = 1'b1;
         end
         else if (fin.sel > s.axis_count)
         begin
            // last valid axis stays selected
            irq_set[`ASPS_IRQ_INVALID] = 1'b1;
            n.ring[s.ring_ptr] = `ASPS_ERR_INVALID;
            n.ring_ptr = s.ring_ptr + 2'h1;
            n.ring_cnt = (s.ring_cnt == 3'h4) ? s.ring_cnt : s.ring_cnt + 3'h1;
         end
         else
         begin
            n.axis = fin.sel;
            irq_set[`ASPS_IRQ_STROBE] = 1'b1;
         end
      end

      // preset shifts the shown value of the selected axis to its preset
      if (preset_rise && (s.axis != 3'h0))
      begin
         n.offset[s.axis] = s.preset[s.axis] - axis_position[s.axis];
         irq_set[`ASPS_IRQ_PRESET] = 1'b1;
      end

      // output word is rebuilt every cycle that hold is low from the selection in force
      pos = axis_position[s.axis] + s.offset[s.axis];
      if (!fin.hold)
      begin
         if (s.axis == 3'h0)
         begin
            n.dout = '0;
         end
         else
         begin
            n.dout = {s.axis, axis_fault[s.axis], pos};
         end
      end
      n.oe_n = fin.release_req;

      // consecutive time-outs count up, a good measurement restarts the run
      if (measure_done)
      begin
         n.tmo_cnt = 3'h0;
      end
      else if (measure_timeout && (s.tmo_cnt < `ASPS_TMO_LIMIT))
      begin
         n.tmo_cnt = s.tmo_cnt + 3'h1;
      end

      // periodic self-check; a latched fault keeps the relay open until cleared
      n.chk_cnt = check_tick ? asps_pkg::asps_cnt_t'(CHECK_CYCLES - 1)
                             : s.chk_cnt - 1'b1;
      if (check_tick)
      begin
         if (any_fault)
         begin
            n.fault = 1'b1;
            n.ready = 1'b0;
            if (s.ready)
            begin
               irq_set[`ASPS_IRQ_NOTREADY] = 1'b1;
            end
            if (!s.fault)
            begin
               n.ring[s.ring_ptr] = encoder_missing ? `ASPS_ERR_MISSING
                                  : readback_mismatch ? `ASPS_ERR_READBACK
                                  : bad_position ? `ASPS_ERR_BADPOS
                                  : `ASPS_ERR_TIMEOUT;
               n.ring_ptr = s.ring_ptr + 2'h1;
               n.ring_cnt = (s.ring_cnt == 3'h4) ? s.ring_cnt : s.ring_cnt + 3'h1;
            end
         end
         else if (!s.fault && !s.clr_wait)
         begin
            n.ready = 1'b1;
         end
      end

      // clearing empties the ring and re-arms the relay after the delay
      if (clear_rise)
      begin
         n.clr_wait = 1'b1;
         n.clr_cnt = asps_pkg::asps_cnt_t'(CLEAR_CYCLES - 1);
         n.ring = '0;
         n.ring_cnt = 3'h0;
         n.ring_ptr = 2'h0;
      end
      else if (s.clr_wait)
      begin
         if (s.clr_cnt == '0)
         begin
            n.clr_wait = 1'b0;
            n.fault = 1'b0;
            n.ready = 1'b1;
         end
         else
         begin
            n.clr_cnt = s.clr_cnt - 1'b1;
         end
      end

      // a new event beats a clear written in the same cycle
      n.irq_stat = (s.irq_stat & ~irq_clr) | irq_set;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.axis_count <= `ASPS_AXES_RST;
         s.oe_n <= 1'b1;
         s.chk_cnt <= asps_pkg::asps_cnt_t'(CHECK_CYCLES - 1);
      end
      else
      begin
         s <= n;
      end
   end

   assign axi_rsp.awready = !s.aw_held && !s.bvalid;
   assign axi_rsp.wready = !s.w_held && !s.bvalid;
   assign axi_rsp.bvalid = s.bvalid;
   assign axi_rsp.bresp = s.bresp;
   assign axi_rsp.arready = !s.rvalid;
   assign axi_rsp.rvalid = s.rvalid;
   assign axi_rsp.rdata = s.rdata;
   assign axi_rsp.rresp = s.rresp;

   assign parallel_data_out = s.dout;
   assign parallel_data_oe_n = s.oe_n;
   assign ready_relay_out = s.ready;
   assign irq = |(s.irq_stat & s.irq_en);
endmodule
`default_nettype wire

/* File: asps_port_assertions.sv */
// concurrent checks on the ports of the axis select parallel port
`timescale 1ns/1ps
`default_nettype none
module asps_chk #(
   parameter int FILTER_CYCLES = 100000,
   parameter int FAST_CYCLES = 40000,
   parameter int CHECK_CYCLES = 10000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire asps_pkg::asps_axi_req_t axi_req,
   input wire asps_pkg::asps_axi_rsp_t axi_rsp,
   input wire logic output_hold_in,
   input wire logic output_release_in,
   input wire logic encoder_missing,
   input wire logic [23:0] parallel_data_out,
   input wire logic parallel_data_oe_n,
   input wire logic ready_relay_out
);
   int hold_run;
   int rel_run;
   int miss_run;
   default clocking dcb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hold_run <= 0;
         rel_run <= 0;
         miss_run <= 0;
      end
      else
      begin
         hold_run <= output_hold_in ? hold_run + 1 : 0;
         rel_run <= output_release_in ? rel_run + 1 : 0;
         miss_run <= (encoder_missing && ready_relay_out) ? miss_run + 1 : 0;
      end
   end
   a_reset_quiet: assert property ($rose(aresetn) |->
      parallel_data_out == 24'h000000 && parallel_data_oe_n && !ready_relay_out)
      else $error("outputs not quiet after reset");
   a_bresp_holds: assert property (axi_rsp.bvalid && !axi_req.bready |=>
      axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write response dropped early");
   a_rdata_holds: assert property (axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped early");
   a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("read answer late");
   a_hold_freeze: assert property (hold_run >= FILTER_CYCLES + 5 |=> $stable(parallel_data_out))
      else $error("output moved while held");
   a_release_float: assert property (rel_run >= FILTER_CYCLES + 5 |-> parallel_data_oe_n)
      else $error("bus not released");
   a_filter_wait: assert property ($rose(parallel_data_oe_n) |-> rel_run >= FAST_CYCLES)
      else $error("release taken before filter time");
   a_zero_axis: assert property (parallel_data_out[23:21] == 3'h0 |-> parallel_data_out == 24'h000000)
      else $error("axis zero word not all low");
   a_ready_fault: assert property (miss_run <= CHECK_CYCLES + 3)
      else $error("ready held during fault");
   c_release: cover property ($rose(parallel_data_oe_n));
   c_ready_drop: cover property ($fell(ready_relay_out));
   c_axis_change: cover property ($changed(parallel_data_out[23:21]));
endmodule
bind asps_port asps_chk #(
   .FILTER_CYCLES(FILTER_CYCLES),
   .FAST_CYCLES(FAST_CYCLES),
   .CHECK_CYCLES(CHECK_CYCLES)
) u_chk (
   .aclk(aclk),
   .aresetn(aresetn),
   .axi_req(axi_req),
   .axi_rsp(axi_rsp),
   .output_hold_in(output_hold_in),
   .output_release_in(output_release_in),
   .encoder_missing(encoder_missing),
   .parallel_data_out(parallel_data_out),
   .parallel_data_oe_n(parallel_data_oe_n),
   .ready_relay_out(ready_relay_out)
);
`default_nettype wire

/* File: asps_plc.sv */
// controller model that drives the select and control pins and reads the output bus
`timescale 1ns/1ps
`default_nettype none
module asps_plc (
   input wire logic aclk,
   input wire logic [23:0] parallel_data_out,
   input wire logic parallel_data_oe_n,
   output logic [2:0] sel,
   output logic [5:0] pins,
   output logic [23:0] bus_seen
);
   logic [23:0] last;
   initial
   begin
      sel = 3'h0;
      pins = 6'h00;
   end
   // a released bus shows the inverse of the last word, so a stale value never matches
   assign bus_seen = parallel_data_oe_n ? ~last : parallel_data_out;
   always_ff @(posedge aclk)
   begin
      if (!parallel_data_oe_n)
         last <= parallel_data_out;
   end
   // pins: 0 strobe, 1 clear, 2 hold, 3 release, 4 preset one, 5 preset two
   task automatic drive(input int which, input logic v);
      @(posedge aclk);
      pins[which] <= v;
   endtask
   task automatic strobe_axis(input logic [2:0] n, input int len);
      @(posedge aclk);
      sel <= n;
      repeat (len) @(posedge aclk);
      drive(0, 1'b1);
      repeat (len) @(posedge aclk);
      drive(0, 1'b0);
      repeat (len) @(posedge aclk);
   endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the axis select parallel port
`timescale 1ns/1ps
`default_nettype none
`include "asps_map.svh"
module tb;
   localparam int FILT = 20;
   localparam int FAST = 8;
   localparam int CLR = 30;
   localparam int CHK = 16;
   localparam int SET = FILT + 6;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   asps_pkg::asps_axi_req_t axi_req = '0;
   asps_pkg::asps_axi_rsp_t axi_rsp;
   logic [7:0][19:0] axis_position;
   logic [7:0] axis_fault = 8'h08;
   logic encoder_missing = 1'b0;
   logic [1:0] flt = 2'h0;
   logic measure_timeout = 1'b0;
   logic measure_done = 1'b0;
   logic [23:0] parallel_data_out;
   logic [23:0] bus_seen;
   logic [23:0] saved;
   logic parallel_data_oe_n;
   logic ready_relay_out;
   logic irq;
   logic [2:0] sel;
   logic [5:0] pins;
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   int lat;
   always #50 aclk = ~aclk;
   asps_plc plc (.aclk(aclk), .parallel_data_out(parallel_data_out),
      .parallel_data_oe_n(parallel_data_oe_n), .sel(sel), .pins(pins), .bus_seen(bus_seen));
   asps_port #(.FILTER_CYCLES(FILT), .FAST_CYCLES(FAST), .CLEAR_CYCLES(CLR),
      .CHECK_CYCLES(CHK)) uut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
      .axi_rsp(axi_rsp), .axis_select_bit0(sel[0]), .axis_select_bit1(sel[1]),
      .axis_select_bit2(sel[2]), .axis_strobe_in(pins[0]), .clear_errors_in(pins[1]),
      .output_hold_in(pins[2]), .output_release_in(pins[3]), .preset_one_in(pins[4]),
      .preset_two_in(pins[5]), .axis_position(axis_position), .axis_fault(axis_fault),
      .encoder_missing(encoder_missing), .readback_mismatch(flt[0]), .bad_position(flt[1]),
      .measure_timeout(measure_timeout), .measure_done(measure_done),
      .parallel_data_out(parallel_data_out), .parallel_data_oe_n(parallel_data_oe_n),
      .ready_relay_out(ready_relay_out), .irq(irq));
   task automatic complete_run();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      axi_req.awaddr <= a;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hF;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (axi_req.awvalid && axi_rsp.awready)
            axi_req.awvalid <= 1'b0;
         if (axi_req.wvalid && axi_rsp.wready)
            axi_req.wvalid <= 1'b0;
         // the answer waits one cycle so that the response hold is exercised
         if (axi_rsp.bvalid === 1'b1 && !axi_req.bready)
            axi_req.bready <= 1'b1;
      end
      while (axi_rsp.bvalid !== 1'b1 || !axi_req.bready);
      axi_req.bready <= 1'b0;
      check("bresp", {30'h0, er}, {30'h0, axi_rsp.bresp});
   endtask
   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (axi_req.arvalid && axi_rsp.arready)
            axi_req.arvalid <= 1'b0;
         if (axi_rsp.rvalid === 1'b1 && !axi_req.rready)
            axi_req.rready <= 1'b1;
      end
      while (axi_rsp.rvalid !== 1'b1 || !axi_req.rready);
      axi_req.rready <= 1'b0;
      check(what, exp, axi_rsp.rdata & m);
      check("rresp", {30'h0, er}, {30'h0, axi_rsp.rresp});
   endtask
   function automatic logic [23:0] word(input logic [2:0] n);
      return {n, axis_fault[n], axis_position[n]};
   endfunction
   // strobes an axis in and times the new word from the strobe pin edge
   task automatic pick(input logic [2:0] n, input int filt, input logic [23:0] exp);
      fork
         plc.strobe_axis(n, SET);
         begin
            @(posedge pins[0]);
            lat = 0;
            while (bus_seen !== exp && lat < 4 * SET)
            begin
               @(posedge aclk);
               lat++;
            end
            check("latency", 1, {31'h0, lat > filt && lat <= filt + 8});
         end
      join
      check("word", {8'h00, exp}, {8'h00, bus_seen});
   endtask
   task automatic pulse(input int which);
      plc.drive(which, 1'b1);
      repeat (SET) @(posedge aclk);
      plc.drive(which, 1'b0);
      repeat (SET) @(posedge aclk);
   endtask
   task automatic tmo(input int n);
      repeat (n)
      begin
         @(posedge aclk);
         measure_timeout <= 1'b1;
         @(posedge aclk);
         measure_timeout <= 1'b0;
      end
   endtask
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors = errors + 1;
         complete_run();
      end
   end
   initial
   begin
      for (int k = 0; k < 8; k++)
         axis_position[k] = 20'(20'h0A000 + k * 20'h01111);
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd("ctrl", `ASPS_REG_CTRL, 32'hFFFFFFFF, 32'h70, `ASPS_RESP_OKAY);
      wr(8'h20, 32'h1, `ASPS_RESP_SLVERR);
      rd("hole", 8'h20, 32'hFFFFFFFF, 32'h0, `ASPS_RESP_SLVERR);
      for (int k = 1; k < 8; k++)
         pick(k[2:0], FILT, word(k[2:0]));
      pick(3'h0, FILT, 24'h000000);
      plc.strobe_axis(3'h4, FILT / 2);
      check("glitch", 32'h0, {8'h00, bus_seen});
      wr(`ASPS_REG_CTRL, 32'h30, `ASPS_RESP_OKAY);
      pick(3'h2, FILT, word(3'h2));
      wr(`ASPS_REG_IRQ_EN, 32'h2, `ASPS_RESP_OKAY);
      wr(`ASPS_REG_IRQ_CLR, 32'hF, `ASPS_RESP_OKAY);
      plc.strobe_axis(3'h5, SET);
      check("keep", {8'h00, word(3'h2)}, {8'h00, bus_seen});
      check("irq", 1, {31'h0, irq});
      rd("ring", `ASPS_REG_STATUS, 32'h700, 32'h100, `ASPS_RESP_OKAY);
      wr(`ASPS_REG_IRQ_EN, 32'h0, `ASPS_RESP_OKAY);
      check("mask", 0, {31'h0, irq});
      wr(`ASPS_REG_IRQ_EN, 32'h2, `ASPS_RESP_OKAY);
      wr(`ASPS_REG_IRQ_CLR, 32'h2, `ASPS_RESP_OKAY);
      check("clr", 0, {31'h0, irq});
      pulse(1);
      rd("ring", `ASPS_REG_STATUS, 32'h700, 32'h0, `ASPS_RESP_OKAY);
      wr(`ASPS_REG_CTRL, 32'h71, `ASPS_RESP_OKAY);
      pick(3'h6, FAST, word(3'h6));
      wr(`ASPS_REG_CTRL, 32'h70, `ASPS_RESP_OKAY);
      wr(8'h38, 32'h12345, `ASPS_RESP_OKAY);
      rd("preset", 8'h38, 32'hFFFFF, 32'h12345, `ASPS_RESP_OKAY);
      pulse(4);
      check("pre1", 32'h12345, {12'h0, bus_seen[19:0]});
      wr(8'h38, 32'h00ABC, `ASPS_RESP_OKAY);
      pulse(5);
      check("pre2", 32'h00ABC, {12'h0, bus_seen[19:0]});
      plc.drive(2, 1'b1);
      repeat (SET) @(posedge aclk);
      saved = bus_seen;
      axis_position[6] <= axis_position[6] + 20'h00010;
      repeat (SET) @(posedge aclk);
      check("held", {8'h00, saved}, {8'h00, bus_seen});
      pulse(2);
      check("moved", 32'h00ACC, {12'h0, bus_seen[19:0]});
      plc.drive(3, 1'b1);
      repeat (SET) @(posedge aclk);
      check("float", 1, {31'h0, parallel_data_oe_n});
      pulse(3);
      check("drive", 0, {31'h0, parallel_data_oe_n});
      check("ready", 1, {31'h0, ready_relay_out});
      encoder_missing <= 1'b1;
      repeat (CHK + 3) @(posedge aclk);
      check("drop", 0, {31'h0, ready_relay_out});
      rd("irqst", `ASPS_REG_IRQ_STAT, 32'h4, 32'h4, `ASPS_RESP_OKAY);
      plc.drive(1, 1'b1);
      lat = 0;
      while (ready_relay_out !== 1'b1 && lat < FILT + CLR + 12)
      begin
         @(posedge aclk);
         lat++;
      end
      check("rearm", 1, {31'h0, lat >= CLR && lat < FILT + CLR + 12});
      plc.drive(1, 1'b0);
      repeat (CHK + 3) @(posedge aclk);
      check("again", 0, {31'h0, ready_relay_out});
      encoder_missing <= 1'b0;
      pulse(1);
      repeat (CLR) @(posedge aclk);
      check("back", 1, {31'h0, ready_relay_out});
      flt <= 2'h1;
      repeat (CHK + 3) @(posedge aclk);
      check("rback", 0, {31'h0, ready_relay_out});
      flt <= 2'h2;
      pulse(1);
      repeat (CHK + 3) @(posedge aclk);
      check("badpos", 0, {31'h0, ready_relay_out});
      rd("codes", `ASPS_REG_ERR_RING, 32'hFFFF, 32'h4, `ASPS_RESP_OKAY);
      flt <= 2'h0;
      pulse(1);
      repeat (CLR) @(posedge aclk);
      tmo(4);
      @(posedge aclk);
      measure_done <= 1'b1;
      @(posedge aclk);
      measure_done <= 1'b0;
      tmo(4);
      repeat (CHK + 3) @(posedge aclk);
      check("tmo4", 1, {31'h0, ready_relay_out});
      tmo(1);
      repeat (CHK + 3) @(posedge aclk);
      check("tmo5", 0, {31'h0, ready_relay_out});
      complete_run();
   end
endmodule
`default_nettype wire
